/* File: testbench/ttes_partner.sv */
// Purpose: Far side model: generator set and transfer contactor
// Assumes: One clock, synchronous active-high reset
// Notes:   Emergency loss is commanded by the bench through e_kill
`timescale 1ns/10ps
`default_nettype none
module ttes_partner #(
	parameter int START_CYC = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic eng,
	input wire logic cls_n,
	input wire logic cls_e,
	input wire logic e_kill,
	output logic e_ok,
	output logic e_fb
);
	logic [7:0] run_r;
	logic [1:0] pos_r;

	////////////////////////////////////////////////////////////////////////////////
	// Generator comes up a few cycles after start, drops at once when stopped
	always_ff @(posedge clk) begin
		if (rst || !eng)
			run_r <= 8'h00;
		else if (run_r < 8'(START_CYC))
			run_r <= run_r + 8'h01;
	end
	assign e_ok = eng && (run_r == 8'(START_CYC)) && !e_kill;

	////////////////////////////////////////////////////////////////////////////////
	// Main shaft reports emergency two cycles after the command
	always_ff @(posedge clk) begin
		if (rst)
			pos_r <= 2'h0;
		else
			pos_r <= {pos_r[0], cls_e && !cls_n};
	end
	assign e_fb = pos_r[1];
endmodule
`default_nettype wire

/* File: testbench/ttes_top_bench.sv */
// Purpose: Self-checking bench for the test and exercise sequencer
// Assumes: Tick of 10 cycles, so one delay unit is 10 cycles
// Notes:   Register rows first, then sequence scenarios by hand
`timescale 1ns/10ps
`default_nettype none
module ttes_top_bench;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] wr; logic [31:0] q;} ttes_row_t;
	logic clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, q;
	logic awready, wready, bvalid, arready, rvalid, e_ok, e_fb, e_kill = 0;
	logic [1:0] bresp, rresp, r;
	logic [4:0] pins = 0;
	logic tpw = 0, spw = 0, src_n = 1, sync = 0, peak = 0;
	logic [5:0] outs;
	int fails = 0, n_compared = 0, waited, k;
	string names [6] = '{"engine", "close_n", "close_e", "load_bank", "load_ctrl", "fail_sync"};
	ttes_row_t rows [6] = '{
		'{ttes_pkg::A_CTRL, 32'hFFFFFFFF, ttes_pkg::RESP_OK, 32'h0000001F},
		'{ttes_pkg::A_EXEN, 32'hFFFFFFFF, ttes_pkg::RESP_OK, 32'h0000000F},
		'{ttes_pkg::A_DLY0, 32'h00012345, ttes_pkg::RESP_OK, 32'h00002345},
		'{ttes_pkg::A_STAT, 32'h00000000, ttes_pkg::RESP_OK, 32'h00000020},
		'{8'h40, 32'hFFFFFFFF, ttes_pkg::RESP_SLV, 32'h00000000},
		'{8'h02, 32'h00000001, ttes_pkg::RESP_SLV, 32'h00000000}};

	////////////////////////////////////////////////////////////////////////////////
	// Clock, design, far side
	always #50 clk = ~clk;
	ttes_top #(.TICK_CYC(10), .NEX(4)) uut (.CORE_CLK(clk), .SRST(srst),
		.AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid),
		.WREADY(wready), .WDATA(wdata), .WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready),
		.BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
		.RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
		.PB_START(pins[0]), .PB_END(pins[1]), .PB_CANCEL(pins[2]), .PB_PROG(pins[3]),
		.TEST_PW_OK(tpw), .SETUP_PW_OK(spw), .SRC_N_OK(src_n), .SRC_E_OK(e_ok),
		.SRC_IN_SYNC(sync), .PEAK_SHAVE(peak), .CONT_E_FB(e_fb), .EXER_STOP(1'b0),
		.EXER_DUE({3'h0, pins[4]}), .ENGINE_START(outs[0]), .CLOSE_N(outs[1]),
		.CLOSE_E(outs[2]), .LOAD_BANK(outs[3]), .LOAD_CTRL(outs[4]), .FAIL_SYNC(outs[5]));
	ttes_partner far (.clk(clk), .rst(srst), .eng(outs[0]), .cls_n(outs[1]),
		.cls_e(outs[2]), .e_kill(e_kill), .e_ok(e_ok), .e_fb(e_fb));

	////////////////////////////////////////////////////////////////////////////////
	// Report and compare
	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Waits for an output level, bounded
	task automatic wait_out(input int i, input logic v, input int lim);
		waited = 0;
		while (outs[i] !== v && waited < lim) begin
			@(negedge clk);
			waited++;
		end
		chk(names[i], v, outs[i]);
		if (outs[i] !== v)
			test_done();
	endtask
	// Output must stay at one level for n cycles
	task automatic hold_out(input int i, input logic v, input int n);
		logic ok;
		ok = 1;
		repeat (n) begin
			@(negedge clk);
			if (outs[i] !== v)
				ok = 0;
		end
		chk(names[i], v, ok ? v : ~v);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Bus master: one write or one read, held until each handshake
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		k = 0;
		@(posedge clk);
		if (w) begin
			awvalid <= 1;
			wvalid <= 1;
			awaddr <= a;
			wdata <= d;
			bready <= 1;
		end else begin
			arvalid <= 1;
			araddr <= a;
			rready <= 1;
		end
		do @(negedge clk); while (!(w ? awready && wready : arready) && ++k < 50);
		@(posedge clk);
		awvalid <= 0;
		wvalid <= 0;
		arvalid <= 0;
		do @(negedge clk); while (!(w ? bvalid : rvalid) && ++k < 50);
		q = rdata;
		r = w ? bresp : rresp;
		@(posedge clk);
		bready <= 0;
		rready <= 0;
		if (k >= 50) begin
			fails++;
			test_done();
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 0);
		chk("rdata", e, q);
	endtask
	// Pulse on a pushbutton or event pin
	task automatic press(input int i);
		@(posedge clk);
		pins[i] <= 1;
		repeat (5) @(posedge clk);
		pins[i] <= 0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		srst <= 0;
		foreach (rows[j]) begin
			bus(1, rows[j].a, rows[j].d);
			chk("bresp", rows[j].wr, r);
			bus(0, rows[j].a, 0);
			chk("rresp", rows[j].wr, r);
			chk("rdata", rows[j].q, q);
		end
		// Second reset in mid-run restores defaults
		srst <= 1;
		repeat (8) @(posedge clk);
		srst <= 0;
		rdchk(ttes_pkg::A_CTRL, 32'h00000000);
		rdchk(ttes_pkg::A_EXEN, 32'h00000000);
		rdchk(ttes_pkg::A_DLY0, 32'h00000005);
		rdchk(ttes_pkg::A_STAT, 32'h00000020);
		for (int j = 0; j < 8; j++)
			bus(1, ttes_pkg::A_DLY0 + 8'(4 * j), (j == ttes_pkg::D_FSYNC) ? 3 : 2);
		// Start without password is ignored
		press(0);
		hold_out(0, 0, 40);
		// Standard loaded test
		@(posedge clk) tpw <= 1;
		press(0);
		wait_out(0, 1, 10);
		wait_out(4, 1, 5);
		hold_out(2, 0, 8);
		wait_out(2, 1, 40);
		chk("close_n", 0, outs[1]);
		press(1);
		hold_out(1, 0, 8);
		wait_out(1, 1, 40);
		chk("close_e", 0, outs[2]);
		hold_out(0, 1, 8);
		wait_out(0, 0, 40);
		// Programmed transition, both ways through off
		bus(1, ttes_pkg::A_CTRL, 32'(ttes_pkg::TT_PROG));
		press(0);
		wait_out(1, 0, 50);
		hold_out(2, 0, 8);
		wait_out(2, 1, 40);
		press(1);
		wait_out(2, 0, 50);
		hold_out(1, 0, 8);
		wait_out(1, 1, 40);
		wait_out(0, 0, 60);
		// Closed transition, manual override, then emergency loss
		bus(1, ttes_pkg::A_CTRL, 32'(ttes_pkg::TT_CLSD));
		press(0);
		hold_out(2, 0, 45);
		wait_out(5, 1, 60);
		chk("close_e", 0, outs[2]);
		@(posedge clk) sync <= 1;
		wait_out(2, 1, 15);
		wait_out(1, 0, 1100);
		chk("overlap", 1, waited < 1000);
		@(posedge clk) e_kill <= 1;
		wait_out(1, 1, 15);
		wait_out(2, 0, 5);
		wait_out(0, 0, 60);
		@(posedge clk) e_kill <= 0;
		sync <= 0;
		// Closed, manual override: programmed transfer needs setup password
		press(0);
		wait_out(5, 1, 80);
		press(3);
		hold_out(1, 1, 8);
		@(posedge clk) spw <= 1;
		press(3);
		wait_out(1, 0, 15);
		wait_out(2, 1, 40);
		press(1);
		wait_out(5, 1, 80);
		press(3);
		wait_out(2, 0, 15);
		wait_out(1, 1, 40);
		wait_out(0, 0, 60);
		@(posedge clk) spw <= 0;
		// Closed transition with automatic override, synced retransfer
		bus(1, ttes_pkg::A_CTRL, 32'h00000006);
		press(0);
		wait_out(1, 0, 120);
		hold_out(2, 0, 8);
		wait_out(2, 1, 40);
		@(posedge clk) sync <= 1;
		press(1);
		wait_out(1, 1, 60);
		wait_out(2, 0, 1100);
		chk("overlap", 1, waited < 1000);
		wait_out(0, 0, 60);
		@(posedge clk) sync <= 0;
		// Exercise disabled, then unloaded exercise ended early
		bus(1, ttes_pkg::A_CTRL, 32'h00000000);
		press(4);
		hold_out(0, 0, 30);
		bus(1, ttes_pkg::A_EXEN, 32'h00000001);
		press(4);
		wait_out(0, 1, 10);
		wait_out(3, 1, 5);
		hold_out(2, 0, 30);
		press(1);
		wait_out(0, 0, 60);
		// Peak shave skips the exercise and flags it
		@(posedge clk) peak <= 1;
		press(4);
		hold_out(0, 0, 30);
		bus(0, ttes_pkg::A_STAT, 0);
		chk("skip", 1, q[ttes_pkg::ST_SKIP]);
		bus(1, ttes_pkg::A_STAT, 32'h00000200);
		bus(0, ttes_pkg::A_STAT, 0);
		chk("skip", 0, q[ttes_pkg::ST_SKIP]);
		@(posedge clk) peak <= 0;
		// Closed loaded exercise never syncs, cancelled
		bus(1, ttes_pkg::A_CTRL, 32'h0000000A);
		press(4);
		wait_out(0, 1, 10);
		hold_out(2, 0, 40);
		press(2);
		wait_out(0, 0, 80);
		chk("close_e", 0, outs[2]);
		// Loaded standard exercise, then normal source lost
		bus(1, ttes_pkg::A_CTRL, 32'h00000008);
		press(4);
		wait_out(2, 1, 60);
		@(posedge clk) src_n <= 0;
		repeat (10) @(posedge clk);
		bus(0, ttes_pkg::A_STAT, 0);
		chk("state", 0, q[3:0]);
		chk("exercise", 0, q[11]);
		chk("engine", 1, outs[0]);
		test_done();
	end
endmodule
`default_nettype wire

/* File: verilog/ttes_pkg.sv */
// Purpose: Shared constants and types for the transfer test and exercise sequencer
// Assumes: 10 MHz core clock, 1 ms sequence tick, AXI4-Lite register access
// Notes:   Delay values are counted in ticks of one millisecond
package ttes_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Bus
	localparam int AW = 8;
	localparam logic [AW-1:0] A_CTRL = 8'h00;
	localparam logic [AW-1:0] A_STAT = 8'h04;
	localparam logic [AW-1:0] A_EXEN = 8'h08;
	localparam logic [AW-1:0] A_DLY0 = 8'h10;
	localparam logic [AW-1:0] A_DLYE = 8'h30;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLV = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Control fields
	localparam int C_TT = 0;
	localparam int C_OVR = 2;
	localparam int C_EXLD = 3;
	localparam int C_TUNL = 4;
	localparam int CW = 5;
	localparam logic [CW-1:0] CTRL_RST = 5'h00;
	localparam logic [1:0] TT_PROG = 2'h1;
	localparam logic [1:0] TT_CLSD = 2'h2;
	localparam int ST_SKIP = 9;

	////////////////////////////////////////////////////////////////////////////////
	// Delays, in ms ticks
	localparam int DW = 16;
	localparam int ND = 8;
	localparam int D_N2E = 0;
	localparam int D_N2OFF = 1;
	localparam int D_OFF2E = 2;
	localparam int D_E2N = 3;
	localparam int D_E2OFF = 4;
	localparam int D_OFF2N = 5;
	localparam int D_FSYNC = 6;
	localparam int D_COOL = 7;
	localparam logic [DW-1:0] DLY_RST = 16'h0005;
	localparam int CLK_KHZ = 10000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_KHZ * TICK_MS;
	localparam int OVERLAP_MS = 100;
	localparam logic [DW-1:0] OVL_TK = DW'(OVERLAP_MS / TICK_MS - 2);

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised input positions
	localparam int I_START = 0;
	localparam int I_END = 1;
	localparam int I_CANCEL = 2;
	localparam int I_PROG = 3;
	localparam int I_TPW = 4;
	localparam int I_SPW = 5;
	localparam int I_NOK = 6;
	localparam int I_EOK = 7;
	localparam int I_SYNC = 8;
	localparam int I_PEAK = 9;
	localparam int I_EFB = 10;
	localparam int I_STOP = 11;
	localparam int NFIX = 12;
	localparam int NEX = 4;

	typedef enum logic [3:0] {S_IDLE, S_UNLD, S_FDLY, S_FSYN, S_FOFF, S_FOVL, S_ONE,
		S_RDLY, S_RSYN, S_ROFF, S_ROVL, S_COOL} ttes_st_t;

endpackage

/* File: verilog/ttes_top.sv */
// Purpose: Loaded test and exercise sequencer of a transfer switch controller
// Assumes: Single clock, synchronous reset, pins synchronised here
// Notes:   Contactor commands are held in flip-flops; auto transfer lies outside
// Operation
// [R1] Emergency loss in loaded test: retransfer at once
// [R2] Standard: N-to-E delay, then move to E
// [R3] Programmed: N-to-off delay, off-to-E delay
// [R4] Closed: close E on sync, open N fast
// [R5] Fail-to-sync with auto override: go via off
// [R6] Manual override: keep syncing, prog or cancel
// [R7] Standard retransfer: E-to-N delay, then N
// [R8] Programmed retransfer: E-to-off, then off-to-N
// [R9] Closed retransfer on sync; prog, no cancel
// [R10] Engine start held through cool-down
// [R11] Loaded test start needs test password
// [R12] Test end runs all retransfer delays
// [R13] Exercise during test or peak shave skipped
// [R14] Normal loss ends exercise, hands over
// [R15] Disabled exercise events do not run
// [R16] End pushbutton stops exercise early
// [R17] Unloaded exercise runs engine, contactor stays
// [R18] Load bank on unloaded, off at E
// [R19] Loaded exercise transfers, closed waits sync
// [R20] Cancel aborts unsynced closed exercise
// [R21] Loaded test starts engine at once
// [R22] Common tick times every delay, reloaded
`timescale 1ns/10ps
`default_nettype none
module ttes_top #(
	parameter int TICK_CYC = ttes_pkg::TICK_CYC,
	parameter int NEX = ttes_pkg::NEX
) (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [ttes_pkg::AW-1:0] AWADDR,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [ttes_pkg::AW-1:0] ARADDR,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic PB_START,
	input wire logic PB_END,
	input wire logic PB_CANCEL,
	input wire logic PB_PROG,
	input wire logic TEST_PW_OK,
	input wire logic SETUP_PW_OK,
	input wire logic SRC_N_OK,
	input wire logic SRC_E_OK,
	input wire logic SRC_IN_SYNC,
	input wire logic PEAK_SHAVE,
	input wire logic CONT_E_FB,
	input wire logic EXER_STOP,
	input wire logic [NEX-1:0] EXER_DUE,
	output logic ENGINE_START,
	output logic CLOSE_N,
	output logic CLOSE_E,
	output logic LOAD_BANK,
	output logic LOAD_CTRL,
	output logic FAIL_SYNC
);
	localparam int NS = ttes_pkg::NFIX + NEX;
	localparam int PW = $clog2(TICK_CYC);
	localparam logic [PW-1:0] PRE_TOP = PW'(TICK_CYC - 1);
	localparam int OVL_CYC = ttes_pkg::OVERLAP_MS * TICK_CYC / ttes_pkg::TICK_MS;

	// Byte-lane merge of a write into an old word
	function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] d, logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i+:8] = d[8*i+:8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detect
	logic [NS-1:0] raw, s1_r, s2_r, s3_r, edg;
	assign raw = {EXER_DUE, EXER_STOP, CONT_E_FB, PEAK_SHAVE, SRC_IN_SYNC, SRC_E_OK,
		SRC_N_OK, SETUP_PW_OK, TEST_PW_OK, PB_PROG, PB_CANCEL, PB_END, PB_START};
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign edg = s2_r & ~s3_r;

	// Named input events and levels
	wire pb_start = edg[ttes_pkg::I_START];
	wire pb_end = edg[ttes_pkg::I_END];
	wire pb_cancel = edg[ttes_pkg::I_CANCEL];
	wire pb_prog = edg[ttes_pkg::I_PROG];
	wire ex_stop = edg[ttes_pkg::I_STOP];
	wire tpw = s2_r[ttes_pkg::I_TPW];
	wire spw = s2_r[ttes_pkg::I_SPW];
	wire n_ok = s2_r[ttes_pkg::I_NOK];
	wire e_ok = s2_r[ttes_pkg::I_EOK];
	wire insync = s2_r[ttes_pkg::I_SYNC];
	wire peak = s2_r[ttes_pkg::I_PEAK];
	wire e_fb = s2_r[ttes_pkg::I_EFB];
	wire [NEX-1:0] ex_edg = edg[ttes_pkg::NFIX+:NEX];

	////////////////////////////////////////////////////////////////////////////////
	// Common millisecond tick
	logic [PW-1:0] pre_r;
	wire tick = pre_r == PRE_TOP;
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			pre_r <= '0;
		end else begin
			pre_r <= tick ? '0 : pre_r + 1'b1; // R22
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file, AXI4-Lite slave
	logic [ttes_pkg::CW-1:0] ctrl_r;
	logic [NEX-1:0] exen_r;
	logic [ttes_pkg::DW-1:0] dly_r [ttes_pkg::ND];
	logic bv_r, rv_r, skip_r;
	logic [1:0] br_r, rr_r;
	logic [31:0] rd_r;
	logic [31:0] stat;

	// Write decode
	wire wr_go = AWVALID & WVALID & ~bv_r;
	wire wr_ctl = AWADDR == ttes_pkg::A_CTRL;
	wire wr_st = AWADDR == ttes_pkg::A_STAT;
	wire wr_ex = AWADDR == ttes_pkg::A_EXEN;
	wire wr_dl = AWADDR >= ttes_pkg::A_DLY0 && AWADDR < ttes_pkg::A_DLYE && AWADDR[1:0] == 2'h0;
	wire [ttes_pkg::AW-1:0] wr_off = AWADDR - ttes_pkg::A_DLY0; // Byte offset from delay block base
	wire [2:0] wr_ix = wr_off[4:2];
	wire [31:0] w_ctl = mrg(32'(ctrl_r), WDATA, WSTRB);
	wire [31:0] w_ex = mrg(32'(exen_r), WDATA, WSTRB);
	wire skip_clr = wr_go & wr_st & WSTRB[ttes_pkg::ST_SKIP/8] & WDATA[ttes_pkg::ST_SKIP];
	assign AWREADY = wr_go;
	assign WREADY = wr_go;

	// Read decode
	wire rd_go = ARVALID & ~rv_r;
	wire rd_dl = ARADDR >= ttes_pkg::A_DLY0 && ARADDR < ttes_pkg::A_DLYE && ARADDR[1:0] == 2'h0;
	wire [ttes_pkg::AW-1:0] rd_off = ARADDR - ttes_pkg::A_DLY0; // Byte offset from delay block base
	wire [31:0] rd_w = (ARADDR == ttes_pkg::A_CTRL) ? 32'(ctrl_r) :
		(ARADDR == ttes_pkg::A_STAT) ? stat :
		(ARADDR == ttes_pkg::A_EXEN) ? 32'(exen_r) :
		rd_dl ? 32'(dly_r[rd_off[4:2]]) : 32'h0000_0000;
	wire rd_hit = ARADDR == ttes_pkg::A_CTRL || ARADDR == ttes_pkg::A_STAT ||
		ARADDR == ttes_pkg::A_EXEN || rd_dl;
	assign ARREADY = rd_go;

	// Response channels
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			bv_r <= 1'b0;
			br_r <= ttes_pkg::RESP_OK;
			rv_r <= 1'b0;
			rr_r <= ttes_pkg::RESP_OK;
			rd_r <= 32'h0000_0000;
		end else begin
			if (wr_go) begin
				bv_r <= 1'b1;
				br_r <= (wr_ctl | wr_st | wr_ex | wr_dl) ? ttes_pkg::RESP_OK : ttes_pkg::RESP_SLV;
			end else if (BREADY) begin
				bv_r <= 1'b0;
			end
			if (rd_go) begin
				rv_r <= 1'b1;
				rr_r <= rd_hit ? ttes_pkg::RESP_OK : ttes_pkg::RESP_SLV;
				rd_r <= rd_w;
			end else if (RREADY) begin
				rv_r <= 1'b0;
			end
		end
	end
	assign BVALID = bv_r;
	assign BRESP = br_r;
	assign RVALID = rv_r;
	assign RDATA = rd_r;
	assign RRESP = rr_r;

	// Control and exercise enable registers
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ctrl_r <= ttes_pkg::CTRL_RST;
			exen_r <= '0;
		end else begin
			if (wr_go && wr_ctl) begin
				ctrl_r <= w_ctl[ttes_pkg::CW-1:0];
			end
			if (wr_go && wr_ex) begin
				exen_r <= w_ex[NEX-1:0]; // R15
			end
		end
	end

	// One delay register per sequence phase
	for (genvar g = 0; g < ttes_pkg::ND; g++) begin : g_dly
		wire [31:0] w_dl = mrg(32'(dly_r[g]), WDATA, WSTRB);
		always_ff @(posedge CORE_CLK) begin
			if (SRST) begin
				dly_r[g] <= ttes_pkg::DLY_RST;
			end else if (wr_go && wr_dl && wr_ix == 3'(g)) begin
				dly_r[g] <= w_dl[ttes_pkg::DW-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer decode
	ttes_pkg::ttes_st_t st_r, st_nxt;
	logic [ttes_pkg::DW-1:0] tmr_r, fs_r;
	logic cn_r, ce_r, eng_r, test_r, exer_r, eseen_r, lb_r, ldc_r, fsw_r;
	wire [1:0] tt = ctrl_r[ttes_pkg::C_TT+:2];
	wire prog = tt == ttes_pkg::TT_PROG;
	wire clsd = tt == ttes_pkg::TT_CLSD;
	wire ovr = ctrl_r[ttes_pkg::C_OVR];
	wire idle = st_r == ttes_pkg::S_IDLE;
	wire idle_nxt = st_nxt == ttes_pkg::S_IDLE;
	wire tdone = tmr_r == '0;
	wire fs_exp = fs_r == '0;
	wire t_go = idle & pb_start & tpw;
	wire ex_due = |(ex_edg & exen_r);
	wire ex_go = ex_due & idle & ~peak & ~t_go;
	wire skip_set = ex_due & ~ex_go;
	wire endreq = pb_end | (exer_r & ex_stop);
	wire man_prog = fs_exp & (ovr | (pb_prog & spw));
	wire at_n = cn_r & ~ce_r;
	wire lded = ~idle && st_r != ttes_pkg::S_UNLD && st_r != ttes_pkg::S_COOL &&
		st_r != ttes_pkg::S_ROFF;
	wire e_fail = eseen_r & ~e_ok & lded;
	wire n_fail = exer_r & ~n_ok & ~idle;
	wire to_sync = st_nxt != st_r &&
		(st_nxt == ttes_pkg::S_FSYN || st_nxt == ttes_pkg::S_RSYN);

	// Delay loaded when a phase is entered
	wire [ttes_pkg::DW-1:0] ld_val =
		(st_nxt == ttes_pkg::S_FDLY) ? dly_r[prog ? ttes_pkg::D_N2OFF : ttes_pkg::D_N2E] :
		(st_nxt == ttes_pkg::S_FOFF) ? dly_r[ttes_pkg::D_OFF2E] :
		(st_nxt == ttes_pkg::S_RDLY) ? dly_r[prog ? ttes_pkg::D_E2OFF : ttes_pkg::D_E2N] :
		(st_nxt == ttes_pkg::S_ROFF) ? dly_r[ttes_pkg::D_OFF2N] :
		(st_nxt == ttes_pkg::S_COOL) ? dly_r[ttes_pkg::D_COOL] :
		(st_nxt == ttes_pkg::S_FOVL || st_nxt == ttes_pkg::S_ROVL) ? ttes_pkg::OVL_TK : '0;

	// Next state
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ttes_pkg::S_IDLE: begin
				if (t_go) begin
					st_nxt = ctrl_r[ttes_pkg::C_TUNL] ? ttes_pkg::S_UNLD : ttes_pkg::S_FDLY; // R11
				end else if (ex_go) begin
					st_nxt = ctrl_r[ttes_pkg::C_EXLD] ? ttes_pkg::S_FDLY : ttes_pkg::S_UNLD; // R19
				end
			end
			ttes_pkg::S_UNLD: begin
				if (endreq) begin
					st_nxt = ttes_pkg::S_COOL; // R16
				end
			end
			ttes_pkg::S_FDLY: begin
				if (endreq) begin
					st_nxt = ttes_pkg::S_COOL;
				end else if (tdone) begin
					st_nxt = prog ? ttes_pkg::S_FOFF :
						clsd ? ttes_pkg::S_FSYN : ttes_pkg::S_ONE; // R2 R3 R4
				end
			end
			ttes_pkg::S_FSYN: begin
				if (insync) begin
					st_nxt = ttes_pkg::S_FOVL; // R4 R19
				end else if (exer_r & (pb_cancel | endreq)) begin
					st_nxt = ttes_pkg::S_COOL; // R20
				end else if (man_prog) begin
					st_nxt = ttes_pkg::S_FOFF; // R5 R6
				end else if (fs_exp & (pb_cancel | pb_end)) begin
					st_nxt = ttes_pkg::S_COOL; // R6
				end
			end
			ttes_pkg::S_FOFF, ttes_pkg::S_FOVL: begin
				if (tdone) begin
					st_nxt = ttes_pkg::S_ONE; // R3 R4
				end
			end
			ttes_pkg::S_ONE: begin
				if (endreq) begin
					st_nxt = ttes_pkg::S_RDLY; // R12 R16
				end
			end
			ttes_pkg::S_RDLY: begin
				if (tdone) begin
					st_nxt = prog ? ttes_pkg::S_ROFF :
						clsd ? ttes_pkg::S_RSYN : ttes_pkg::S_COOL; // R7 R8 R9
				end
			end
			ttes_pkg::S_RSYN: begin
				if (insync) begin
					st_nxt = ttes_pkg::S_ROVL; // R9
				end else if (man_prog) begin
					st_nxt = ttes_pkg::S_ROFF; // R9
				end
			end
			ttes_pkg::S_ROFF, ttes_pkg::S_ROVL, ttes_pkg::S_COOL: begin
				if (tdone) begin
					st_nxt = (st_r == ttes_pkg::S_COOL) ? ttes_pkg::S_IDLE : ttes_pkg::S_COOL; // R8 R10
				end
			end
			default: st_nxt = ttes_pkg::S_IDLE;
		endcase
		if (e_fail) begin
			st_nxt = (prog & ~at_n) ? ttes_pkg::S_ROFF : ttes_pkg::S_COOL; // R1
		end
		if (n_fail) begin
			st_nxt = ttes_pkg::S_IDLE; // R14
		end
	end

	// State, phase timer and fail-to-sync timer
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			st_r <= ttes_pkg::S_IDLE;
			tmr_r <= '0;
			fs_r <= '0;
		end else begin
			st_r <= st_nxt;
			if (st_nxt != st_r) begin
				tmr_r <= ld_val; // R22
			end else if (tick && !tdone) begin
				tmr_r <= tmr_r - 1'b1; // R22
			end
			if (to_sync) begin
				fs_r <= dly_r[ttes_pkg::D_FSYNC]; // R5
			end else if (tick && !fs_exp) begin
				fs_r <= fs_r - 1'b1;
			end
		end
	end

	// Contactor commands follow the phase entered
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			cn_r <= 1'b1;
			ce_r <= 1'b0;
		end else if (st_nxt != st_r) begin
			case (st_nxt)
				ttes_pkg::S_FOFF, ttes_pkg::S_ROFF: begin
					cn_r <= 1'b0; // R3 R8
					ce_r <= 1'b0;
				end
				ttes_pkg::S_FOVL, ttes_pkg::S_ROVL: begin
					cn_r <= 1'b1; // R4 R9
					ce_r <= 1'b1;
				end
				ttes_pkg::S_ONE: begin
					cn_r <= 1'b0; // R2
					ce_r <= 1'b1;
				end
				ttes_pkg::S_COOL: begin
					cn_r <= 1'b1; // R7 R1
					ce_r <= 1'b0;
				end
				default: begin
					cn_r <= cn_r; // R17
					ce_r <= ce_r;
				end
			endcase
		end
	end

	// Run flags, engine start and indicator outputs
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			eng_r <= 1'b0;
			test_r <= 1'b0;
			exer_r <= 1'b0;
			eseen_r <= 1'b0;
			skip_r <= 1'b0;
			lb_r <= 1'b0;
			ldc_r <= 1'b0;
			fsw_r <= 1'b0;
		end else begin
			if (idle && !idle_nxt) begin
				eng_r <= 1'b1; // R21 R17
			end else if (!idle && idle_nxt) begin
				eng_r <= n_fail & ce_r; // R10 R14
			end
			test_r <= idle_nxt ? 1'b0 : (test_r | t_go);
			exer_r <= idle_nxt ? 1'b0 : (exer_r | ex_go);
			eseen_r <= idle_nxt ? 1'b0 : (eseen_r | e_ok);
			skip_r <= skip_set | (skip_r & ~skip_clr); // R13
			lb_r <= st_nxt == ttes_pkg::S_UNLD && !ce_r && !e_fb; // R18
			ldc_r <= st_nxt == ttes_pkg::S_FDLY; // R21
			fsw_r <= (st_r == ttes_pkg::S_FSYN || st_r == ttes_pkg::S_RSYN) && fs_exp;
		end
	end
	assign stat = {20'h0_0000, exer_r, test_r, skip_r, fsw_r, lb_r, ce_r, cn_r, eng_r,
		4'(st_r)};
	assign ENGINE_START = eng_r;
	assign CLOSE_N = cn_r;
	assign CLOSE_E = ce_r;
	assign LOAD_BANK = lb_r;
	assign LOAD_CTRL = ldc_r;
	assign FAIL_SYNC = fsw_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [31:0] ov_r;
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ov_r <= 32'h0000_0000;
		end else begin
			ov_r <= (cn_r & ce_r) ? ov_r + 1'b1 : 32'h0000_0000;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SRST);

	a_engine_at_start: assert property (t_go && !n_fail |=> eng_r && !idle) // R21
		else $error("engine start not raised on test start");
	a_start_no_pw: assert property (idle && !tpw && !ex_go |=> idle) // R11
		else $error("test started without password");
	a_efail_retx: assert property (e_fail && !n_fail |=> st_r == ttes_pkg::S_COOL ||
		st_r == ttes_pkg::S_ROFF) // R1
		else $error("no immediate retransfer on emergency loss");
	a_std_forward: assert property (st_r == ttes_pkg::S_FDLY && tdone && !prog && !clsd &&
		!endreq && !e_fail && !n_fail |=> ce_r && !cn_r) // R2
		else $error("standard forward transfer wrong");
	a_prog_offpos: assert property (st_r == ttes_pkg::S_FOFF |-> !cn_r && !ce_r) // R3
		else $error("not in off position during off delay");
	a_overlap_time: assert property (ov_r < OVL_CYC) // R4
		else $error("sources paralleled too long");
	a_cool_engine: assert property (st_r == ttes_pkg::S_COOL && tdone && !n_fail |=>
		!eng_r) // R10
		else $error("engine start kept after cool-down");
	a_skip_exer: assert property (ex_due && peak |=> skip_r && $stable(st_r)) // R13
		else $error("exercise not skipped");
	a_nfail_exer: assert property (n_fail |=> idle && !exer_r) // R14
		else $error("exercise not ended on normal loss");
	a_lb_at_e: assert property (ce_r |=> !lb_r) // R18
		else $error("load bank on at emergency position");
endmodule
`default_nettype wire
